// >>> shared/irq_status_pkg.sv
// Constants for the interrupt event status block
package irq_status_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CMD_STATE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] MASK_SET_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] MASK_CLR_OFS = 8'h14;
  localparam int OVERRUN_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int SOF_BIT = 2;
  localparam int RESUME_BIT = 3;
  localparam int FATAL_BIT = 4;
  localparam int FRAME_BIT = 5;
  localparam int ROOT_BIT = 6;
  localparam int OWNER_BIT = 30;
  localparam int GATE_BIT = 31;
  localparam int REQ_BIT = 3;
  localparam int TALLY_LSB = 16;
  localparam int TALLY_W = 2;
  localparam int FRAME_MSB = 15;
  localparam logic [31:0] EVENT_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [31:0] EVENT_BITS = 32'h4000007f;
  localparam logic [31:0] MASK_BITS = 32'hc000007f;
  localparam logic [TALLY_W-1:0] TALLY_RESET = 2'h0;
endpackage : irq_status_pkg

// >>> rtl/change_detect.sv
// Flags any change of a same-clock input vector
`timescale 1ns/1ps
`default_nettype none
module change_detect #(
  parameter int WIDTH = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] value_in,
  output logic changed_out
);
  logic [WIDTH-1:0] prev;
  logic primed;
  logic [WIDTH-1:0] next_prev;
  logic next_primed;

  always_comb begin
    next_prev = value_in;
    next_primed = 1'b1;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev <= '0;
      primed <= 1'b0;
    end else begin
      prev <= next_prev;
      primed <= next_primed;
    end
  end

  // No change reported for the first sample after reset
  assign changed_out = primed && (value_in != prev);
endmodule : change_detect
`default_nettype wire

// >>> rtl/irq_event_status.sv
// Interrupt event status register with enables and overrun tally
`timescale 1ns/1ps
`default_nettype none
module irq_event_status
  import irq_status_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter bit MGMT_PIN_PRESENT = 1'b1
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic REG_RD_IN,
  input wire logic REG_WR_IN,
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT,
  input wire logic [31:0] ROOT_HUB_STATE_IN,
  input wire logic [NPORTS*32-1:0] ROOT_PORT_STATE_IN,
  input wire logic [15:0] FRAME_COUNT_IN,
  input wire logic SHARED_FRAME_UPDATED_IN,
  input wire logic SYS_ERROR_IN,
  input wire logic RESUME_SIGNAL_IN,
  input wire logic BUS_WAKE_STATE_IN,
  input wire logic SOF_TOKEN_IN,
  input wire logic DONE_HEAD_WRITTEN_IN,
  input wire logic OVERRUN_IN,
  input wire logic HANDOFF_DONE_IN,
  output logic IRQ_OUT,
  output logic MGMT_IRQ_OUT,
  output logic HALT_OUT,
  output logic DONE_HEAD_HOLD_OUT,
  output logic HANDOFF_REQ_OUT
);

  // Write-one-to-clear update with set priority
  function automatic logic [31:0] w1c_update(input logic [31:0] cur, input logic [31:0] clr,
                                             input logic [31:0] set);
    w1c_update = (cur & ~clr) | set;
  endfunction : w1c_update

  function automatic logic is_access(input logic strobe, input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
    is_access = strobe && (addr == ofs);
  endfunction : is_access

  // State
  logic [31:0] irq_event_reg;
  logic [31:0] irq_mask_set_reg;
  logic owner_handoff_request;
  logic [TALLY_W-1:0] overrun_tally;
  logic [31:0] rdata;
  logic ack;
  logic irq;
  logic mgmt_irq;
  logic resume_meta;
  logic resume_sync;
  logic resume_prev;

  logic [31:0] next_irq_event_reg;
  logic [31:0] next_irq_mask_set_reg;
  logic next_owner_handoff_request;
  logic [TALLY_W-1:0] next_overrun_tally;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_irq;
  logic next_mgmt_irq;
  logic next_resume_meta;
  logic next_resume_sync;
  logic next_resume_prev;

  logic [32+NPORTS*32-1:0] root_state;
  logic root_changed;
  logic frame_msb_toggled;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic wr_event;
  logic wr_mask_set;
  logic wr_mask_clr;
  logic wr_cmd;
  logic handoff_rise;

  assign root_state = {ROOT_PORT_STATE_IN, ROOT_HUB_STATE_IN};

  change_detect #(.WIDTH(32 + NPORTS*32)) u_root_change (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .value_in(root_state),
    .changed_out(root_changed)
  );

  change_detect #(.WIDTH(1)) u_frame_msb (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .value_in(FRAME_COUNT_IN[FRAME_MSB]),
    .changed_out(frame_msb_toggled)
  );

  // Resume line comes from the bus pins
  always_comb begin
    next_resume_meta = RESUME_SIGNAL_IN;
    next_resume_sync = resume_meta;
    next_resume_prev = resume_sync;
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      resume_meta <= 1'b0;
      resume_sync <= 1'b0;
      resume_prev <= 1'b0;
    end else begin
      resume_meta <= next_resume_meta;
      resume_sync <= next_resume_sync;
      resume_prev <= next_resume_prev;
    end
  end

  // Register decode
  always_comb begin
    wr_event = is_access(REG_WR_IN, REG_ADDR_IN, EVENT_OFS);
    wr_mask_set = is_access(REG_WR_IN, REG_ADDR_IN, MASK_SET_OFS);
    wr_mask_clr = is_access(REG_WR_IN, REG_ADDR_IN, MASK_CLR_OFS);
    wr_cmd = is_access(REG_WR_IN, REG_ADDR_IN, CMD_STATE_OFS);
  end

  // Event detection
  always_comb begin
    handoff_rise = wr_cmd && REG_WDATA_IN[REQ_BIT] && !owner_handoff_request;
    set_bits = '0;
    set_bits[OWNER_BIT] = MGMT_PIN_PRESENT && handoff_rise;
    set_bits[ROOT_BIT] = root_changed;
    set_bits[FRAME_BIT] = frame_msb_toggled || SHARED_FRAME_UPDATED_IN;
    set_bits[FATAL_BIT] = SYS_ERROR_IN;
    set_bits[RESUME_BIT] = resume_sync && !resume_prev && !BUS_WAKE_STATE_IN;
    set_bits[SOF_BIT] = SOF_TOKEN_IN;
    set_bits[DONE_BIT] = DONE_HEAD_WRITTEN_IN;
    set_bits[OVERRUN_BIT] = OVERRUN_IN;
    clr_bits = wr_event ? (REG_WDATA_IN & EVENT_BITS) : '0;
  end

  // Register updates
  always_comb begin
    next_irq_event_reg = w1c_update(irq_event_reg, clr_bits, set_bits) & EVENT_BITS;
    next_irq_mask_set_reg = irq_mask_set_reg;
    if (wr_mask_set) begin
      next_irq_mask_set_reg = irq_mask_set_reg | (REG_WDATA_IN & MASK_BITS);
    end else if (wr_mask_clr) begin
      next_irq_mask_set_reg = irq_mask_set_reg & ~(REG_WDATA_IN & MASK_BITS);
    end
    next_owner_handoff_request = owner_handoff_request;
    if (handoff_rise) begin
      next_owner_handoff_request = 1'b1;
    end else if (HANDOFF_DONE_IN) begin
      next_owner_handoff_request = 1'b0;
    end
    next_overrun_tally = overrun_tally;
    if (OVERRUN_IN) begin
      next_overrun_tally = overrun_tally + 2'h1;
    end
  end

  // Interrupt outputs follow the next register values
  always_comb begin
    next_irq = next_irq_mask_set_reg[GATE_BIT] &&
               |(next_irq_event_reg[ROOT_BIT:OVERRUN_BIT] &
                 next_irq_mask_set_reg[ROOT_BIT:OVERRUN_BIT]);
    next_mgmt_irq = next_irq_event_reg[OWNER_BIT] && next_irq_mask_set_reg[OWNER_BIT];
  end

  // Read path
  always_comb begin
    next_ack = REG_RD_IN || REG_WR_IN;
    next_rdata = '0;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        CMD_STATE_OFS: begin
          next_rdata[TALLY_LSB +: TALLY_W] = overrun_tally;
          next_rdata[REQ_BIT] = owner_handoff_request;
        end
        EVENT_OFS: begin
          next_rdata = irq_event_reg;
        end
        MASK_SET_OFS, MASK_CLR_OFS: begin
          next_rdata = irq_mask_set_reg;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      irq_event_reg <= EVENT_RESET;
      irq_mask_set_reg <= MASK_RESET;
      owner_handoff_request <= 1'b0;
      overrun_tally <= TALLY_RESET;
      rdata <= '0;
      ack <= 1'b0;
      irq <= 1'b0;
      mgmt_irq <= 1'b0;
    end else begin
      irq_event_reg <= next_irq_event_reg;
      irq_mask_set_reg <= next_irq_mask_set_reg;
      owner_handoff_request <= next_owner_handoff_request;
      overrun_tally <= next_overrun_tally;
      rdata <= next_rdata;
      ack <= next_ack;
      irq <= next_irq;
      mgmt_irq <= next_mgmt_irq;
    end
  end

  assign REG_RDATA_OUT = rdata;
  assign REG_ACK_OUT = ack;
  assign IRQ_OUT = irq;
  assign MGMT_IRQ_OUT = mgmt_irq;
  // Controller stalls while the fatal flag stands
  assign HALT_OUT = irq_event_reg[FATAL_BIT];
  // Done head write-back held off until flag cleared
  assign DONE_HEAD_HOLD_OUT = irq_event_reg[DONE_BIT];
  assign HANDOFF_REQ_OUT = owner_handoff_request;

endmodule : irq_event_status
`default_nettype wire

// >>> verif/irq_event_status_props.sv
// Assertion checker for the interrupt event status block
`timescale 1ns/1ps
`default_nettype none
module irq_event_status_props
  import irq_status_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic REG_RD_IN,
  input wire logic REG_WR_IN,
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic REG_ACK_OUT,
  input wire logic SYS_ERROR_IN,
  input wire logic DONE_HEAD_WRITTEN_IN,
  input wire logic IRQ_OUT,
  input wire logic HALT_OUT,
  input wire logic DONE_HEAD_HOLD_OUT,
  input wire logic HANDOFF_REQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic clr_fatal;
  logic clr_done;
  assign clr_fatal = REG_WR_IN && REG_ADDR_IN == EVENT_OFS && REG_WDATA_IN[FATAL_BIT];
  assign clr_done = REG_WR_IN && REG_ADDR_IN == EVENT_OFS && REG_WDATA_IN[DONE_BIT];
  sequence s_req;
    REG_WR_IN && REG_ADDR_IN == CMD_STATE_OFS && REG_WDATA_IN[REQ_BIT] ##1 REG_ACK_OUT;
  endsequence
  property p_ack; REG_RD_IN || REG_WR_IN |=> REG_ACK_OUT; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_rdz; !REG_ACK_OUT |-> REG_RDATA_OUT == 32'h00000000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside ack");
  property p_err; SYS_ERROR_IN |=> HALT_OUT; endproperty
  a_err: assert property (p_err) else $error("halt not raised");
  property p_fall; $fell(HALT_OUT) |-> $past(clr_fatal); endproperty
  a_fall: assert property (p_fall) else $error("halt dropped by itself");
  property p_done; DONE_HEAD_WRITTEN_IN |=> DONE_HEAD_HOLD_OUT; endproperty
  a_done: assert property (p_done) else $error("done hold not raised");
  property p_dhold; DONE_HEAD_HOLD_OUT && !clr_done |=> DONE_HEAD_HOLD_OUT; endproperty
  a_dhold: assert property (p_dhold) else $error("done hold lost");
  property p_req; s_req |-> HANDOFF_REQ_OUT; endproperty
  a_req: assert property (p_req) else $error("handoff request not set");
  property p_gate;
    REG_WR_IN && REG_ADDR_IN == MASK_CLR_OFS && REG_WDATA_IN[GATE_BIT] |=> !IRQ_OUT;
  endproperty
  a_gate: assert property (p_gate) else $error("irq with gate off");
endmodule : irq_event_status_props
`default_nettype wire

// >>> verif/host_model.sv
// Host driver model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] rdata_in,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out
);
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 32'h00000000;
  end
  task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_in);
    #1;
    rd_out = !w;
    wr_out = w;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    q = (ack_in === 1'b1) ? rdata_in : 32'hxxxxxxxx;
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : acc
endmodule : host_model
`default_nettype wire

// >>> verif/tb.sv
// Testbench for the interrupt event status block
`timescale 1ns/1ps
`default_nettype none
module tb
  import irq_status_pkg::*;
();
  logic clk, nrst, rd, wr, ack, irq, mgmt, halt, hold, hreq, wake, hdone;
  logic [7:0] addr, ev;
  logic [31:0] wdata, rdata, q;
  int num_errors = 0;
  int cmp_count = 0;
  logic [39:0] rows [6] = '{40'h01_00000004, 40'h02_00000002, 40'h08_00000001,
                            40'h10_00000020, 40'h20_00000040, 40'h40_00000020};
  irq_event_status u_irq_event_status (.CLK_IN(clk), .NRST_IN(nrst), .REG_RD_IN(rd),
    .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .REG_ACK_OUT(ack), .ROOT_HUB_STATE_IN({31'h0, ev[5]}),
    .ROOT_PORT_STATE_IN({ev[5], 127'h0}), .FRAME_COUNT_IN({ev[6], 15'h0}),
    .SHARED_FRAME_UPDATED_IN(ev[4]), .SYS_ERROR_IN(ev[2]), .RESUME_SIGNAL_IN(ev[7]),
    .BUS_WAKE_STATE_IN(wake), .SOF_TOKEN_IN(ev[0]), .DONE_HEAD_WRITTEN_IN(ev[1]),
    .OVERRUN_IN(ev[3]), .HANDOFF_DONE_IN(hdone), .IRQ_OUT(irq), .MGMT_IRQ_OUT(mgmt),
    .HALT_OUT(halt), .DONE_HEAD_HOLD_OUT(hold), .HANDOFF_REQ_OUT(hreq));
  host_model host (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .rd_out(rd),
    .wr_out(wr), .addr_out(addr), .wdata_out(wdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    #1 ev = e;
    @(posedge clk);
    #1 ev = 8'h00;
    repeat (5) @(posedge clk);
    #1;
  endtask : pulse
  initial begin
    #30000;
    num_errors++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    ev = 8'h00;
    wake = 1'b0;
    hdone = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    host.acc(0, EVENT_OFS, 0, q);
    chk(q, EVENT_RESET);
    foreach (rows[i]) begin
      pulse(rows[i][39:32]);
      host.acc(0, EVENT_OFS, 0, q);
      chk(q, rows[i][31:0]);
      chk(32'(hold), 32'(rows[i][DONE_BIT]));
      host.acc(1, EVENT_OFS, 32'h0, q);
      host.acc(0, EVENT_OFS, 0, q);
      chk(q, rows[i][31:0]);
      host.acc(1, EVENT_OFS, EVENT_BITS, q);
      host.acc(0, EVENT_OFS, 0, q);
      chk(q, 32'h0);
      chk(32'(hold), 32'h0);
    end
    wake = 1'b1;
    pulse(8'h80);
    wake = 1'b0;
    host.acc(0, EVENT_OFS, 0, q);
    chk(q, 32'h0);
    pulse(8'h80);
    host.acc(0, EVENT_OFS, 0, q);
    chk(q, 32'h8);
    repeat (3) pulse(8'h08);
    host.acc(0, CMD_STATE_OFS, 0, q);
    chk(q, 32'h0);
    pulse(8'h08);
    host.acc(0, CMD_STATE_OFS, 0, q);
    chk(q, 32'h10000);
    host.acc(1, EVENT_OFS, EVENT_BITS, q);
    host.acc(1, MASK_SET_OFS, 32'hc0000004, q);
    pulse(8'h01);
    chk(32'(irq), 32'h1);
    host.acc(1, EVENT_OFS, 32'h4, q);
    chk(32'(irq), 32'h0);
    pulse(8'h01);
    host.acc(1, MASK_CLR_OFS, 32'h80000000, q);
    chk(32'(irq), 32'h0);
    host.acc(1, CMD_STATE_OFS, 32'h8, q);
    chk(32'({hreq, mgmt}), 32'h3);
    host.acc(0, EVENT_OFS, 0, q);
    chk(q, 32'h40000004);
    hdone = 1'b1;
    @(posedge clk);
    #1 hdone = 1'b0;
    chk(32'(hreq), 32'h0);
    host.acc(1, EVENT_OFS, 32'h40000000, q);
    chk(32'(mgmt), 32'h0);
    host.acc(1, CMD_STATE_OFS, 32'h8, q);
    chk(32'({hreq, mgmt}), 32'h3);
    host.acc(0, 8'h20, 0, q);
    chk(q, 32'h0);
    pulse(8'h04);
    chk(32'(halt), 32'h1);
    nrst = 1'b0;
    @(posedge clk);
    #1 nrst = 1'b1;
    chk(32'({halt, hold, irq, mgmt, hreq}), 32'h0);
    host.acc(1, EVENT_OFS, 32'h10, q);
    host.acc(0, EVENT_OFS, 0, q);
    chk(q, 32'h0);
    summarize();
  end
endmodule : tb
bind irq_event_status irq_event_status_props u_props (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
  .REG_RD_IN(REG_RD_IN), .REG_WR_IN(REG_WR_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_ACK_OUT(REG_ACK_OUT),
  .SYS_ERROR_IN(SYS_ERROR_IN), .DONE_HEAD_WRITTEN_IN(DONE_HEAD_WRITTEN_IN),
  .IRQ_OUT(IRQ_OUT), .HALT_OUT(HALT_OUT), .DONE_HEAD_HOLD_OUT(DONE_HEAD_HOLD_OUT),
  .HANDOFF_REQ_OUT(HANDOFF_REQ_OUT));
`default_nettype wire
